/* hdl/eacc_config.sv */
// Module: energy accumulation, filter/period and checksum configuration registers
`default_nettype none
module eacc_config
(
  // Clock and reset
  input  wire logic        mclk,
  input  wire logic        reset,
  // Register port
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  input  wire logic [11:0] reg_addr,
  input  wire logic [15:0] reg_wdata,
  output var  logic [15:0] reg_rdata_ff,
  // Device context
  input  wire logic        run_bit,
  input  wire logic        highpass_disable,
  input  wire logic        energy_read_strobe,
  input  wire logic        total_reactive_sign,
  input  wire logic        fund_reactive_sign,
  input  wire logic        total_active_sign,
  input  wire logic        fund_active_sign,
  input  wire logic [95:0] cover_data,
  // Settings driven into the metrology core
  output var  logic        use_user_period_ff,
  output var  logic [2:0]  highpass_corner_ff,
  output var  logic        highpass_active_ff,
  output var  logic [3:0]  noload_log2_ff,
  output var  logic        noload_enable_ff,
  output var  logic        reverse_reactive_flag_ff,
  output var  logic        reverse_active_flag_ff,
  output var  logic        energy_clear_ff,
  output var  logic        energy_load_mode_ff,
  output var  logic        energy_interval_mode_ff,
  output var  logic        accumulator_run_ff,
  // Checksum status
  output var  logic        checksum_done_ff,
  output var  logic        checksum_busy_ff,
  output var  logic [15:0] checksum_value_ff
);

  // ------------------------------------------------------------
  // Timing summary
  // ------------------------------------------------------------
  // Offset map: filter/period 0x4AF, energy/power 0x4B0, checksum force 0x4B4,
  // coverage select 0x4B5; every other offset is unmapped.
  // Writes land at the edge that samples reg_wr; reads answer one cycle later
  // through reg_rdata_ff, which falls back to zero when no read is pending.
  // Every setting toward the metrology core is re-registered, so it trails
  // its register by one cycle; a consumer needing the new value must wait.
  // The sign selections pass the chosen sign straight through, one cycle late.
  // highpass_active_ff is only the inverse of the disable input; the corner code is kept.
  // The checksum start is registered too, so busy rises two edges after the
  // force write and done follows once all six coverage slots are walked.
  // Skipped slots still cost a cycle, which keeps the latency fixed and lets
  // firmware poll on a known budget rather than on the coverage pattern.
  // Limitation: force writes that arrive while busy are silently dropped.
  // Reserved bits never reach a flip-flop: the write masks drop them on entry,
  // so a read can never show stale reserved state.

  // ------------------------------------------------------------
  // Address decode, shared by write and read paths
  // ------------------------------------------------------------
  function automatic logic [1:0] decode(input logic [11:0] a);
    logic [1:0] r;
    r = 2'h0;
    if (a == eacc_pkg::FILTER_PERIOD_CONFIG_ADDR)
      r = 2'h0;
    else if (a == eacc_pkg::ENERGY_POWER_CONFIG_ADDR)
      r = 2'h1;
    else if (a == eacc_pkg::CHECKSUM_TRIGGER_ADDR)
      r = 2'h2;
    else
      r = 2'h3;
    return r;
  endfunction

  // True only for the four mapped offsets; others ignore writes and read zero
  function automatic logic hit(input logic [11:0] a);
    return (a == eacc_pkg::FILTER_PERIOD_CONFIG_ADDR) ||
           (a == eacc_pkg::ENERGY_POWER_CONFIG_ADDR)  ||
           (a == eacc_pkg::CHECKSUM_TRIGGER_ADDR)     ||
           (a == eacc_pkg::CHECKSUM_COVERAGE_ADDR);
  endfunction

  logic [15:0] filter_period_ff;
  logic [15:0] nxt_filter_period;
  logic [15:0] energy_power_ff;
  logic [15:0] nxt_energy_power;
  logic [15:0] coverage_ff;
  logic [15:0] nxt_coverage;
  logic        crc_start_ff;
  logic        nxt_crc_start;
  logic [15:0] nxt_rdata;
  logic        crc_done_pulse;
  logic [15:0] crc_result;

  // ------------------------------------------------------------
  // Register writes; reserved bits are masked off on the way in
  // ------------------------------------------------------------
  always_comb
  begin
    nxt_filter_period = filter_period_ff;
    nxt_energy_power  = energy_power_ff;
    nxt_coverage      = coverage_ff;
    nxt_crc_start     = 1'b0;
    if (reg_wr && hit(reg_addr))
    begin
      case (decode(reg_addr))
        2'h0: nxt_filter_period = reg_wdata & eacc_pkg::FILTER_PERIOD_MASK;
        2'h1: nxt_energy_power  = reg_wdata & eacc_pkg::ENERGY_POWER_MASK;
        2'h2: nxt_crc_start     = reg_wdata[eacc_pkg::CHECKSUM_FORCE_BIT];
        default: nxt_coverage   = reg_wdata & eacc_pkg::COVERAGE_MASK;
      endcase
    end
  end

  // ------------------------------------------------------------
  // Read mux; force bit is self-clearing so it always reads zero
  // ------------------------------------------------------------
  always_comb
  begin
    nxt_rdata = 16'h0000;
    if (reg_rd && hit(reg_addr))
    begin
      case (decode(reg_addr))
        2'h0: nxt_rdata = filter_period_ff;
        2'h1: nxt_rdata = energy_power_ff;
        2'h2: nxt_rdata = 16'h0000;
        default: nxt_rdata = coverage_ff;
      endcase
    end
  end

  // Configuration registers and read data
  always_ff @(posedge mclk)
  begin
    if (reset)
    begin
      filter_period_ff <= eacc_pkg::FILTER_PERIOD_RESET;
      energy_power_ff  <= eacc_pkg::ENERGY_POWER_RESET;
      coverage_ff      <= eacc_pkg::COVERAGE_RESET;
      crc_start_ff     <= 1'b0;
      reg_rdata_ff     <= 16'h0000;
    end
    else
    begin
      filter_period_ff <= nxt_filter_period;
      energy_power_ff  <= nxt_energy_power;
      coverage_ff      <= nxt_coverage;
      crc_start_ff     <= nxt_crc_start;
      reg_rdata_ff     <= nxt_rdata;
    end
  end

  // ------------------------------------------------------------
  // Decoded settings toward the metrology core
  // ------------------------------------------------------------
  logic        nxt_use_user_period;
  logic [2:0]  nxt_hp_corner;
  logic        nxt_hp_active;
  logic [3:0]  nxt_noload_log2;
  logic        nxt_noload_en;
  logic        nxt_rev_reactive;
  logic        nxt_rev_active;
  logic        nxt_energy_clear;
  logic        nxt_load_mode;
  logic        nxt_interval_mode;
  logic        nxt_acc_run;
  logic [2:0]  noload_code;

  // Settings are registered so every output leaves a flip-flop
  always_comb
  begin
    noload_code         = energy_power_ff[eacc_pkg::NOLOAD_WINDOW_LSB +: 3];
    nxt_use_user_period = filter_period_ff[eacc_pkg::USER_PERIOD_SELECT_BIT];
    nxt_hp_corner       = filter_period_ff[eacc_pkg::HIGHPASS_CORNER_LSB +: 3];
    nxt_hp_active       = ~highpass_disable;
    // Window length is 2^(6+code) samples; top code turns thresholding off
    nxt_noload_log2     = eacc_pkg::NOLOAD_BASE_LOG2 + {1'b0, noload_code};
    nxt_noload_en       = (noload_code != eacc_pkg::NOLOAD_DISABLE_CODE);
    nxt_rev_reactive    = energy_power_ff[eacc_pkg::SIGN_SEL_REACTIVE_BIT] ?
                          fund_reactive_sign : total_reactive_sign;
    nxt_rev_active      = energy_power_ff[eacc_pkg::SIGN_SEL_ACTIVE_BIT] ?
                          fund_active_sign : total_active_sign;
    // One pulse per read strobe while clear-on-read is set; the accumulator itself owns the zeroing
    nxt_energy_clear    = energy_power_ff[eacc_pkg::CLEAR_ON_READ_BIT] &&
                          energy_read_strobe;
    nxt_load_mode       = energy_power_ff[eacc_pkg::ENERGY_LOAD_MODE_BIT];
    nxt_interval_mode   = energy_power_ff[eacc_pkg::ENERGY_INTERVAL_MODE_BIT];
    nxt_acc_run         = energy_power_ff[eacc_pkg::ACCUMULATOR_ENABLE_BIT] &&
                          run_bit;
  end

  // Settings register stage
  always_ff @(posedge mclk)
  begin
    if (reset)
    begin
      use_user_period_ff       <= 1'b0;
      highpass_corner_ff       <=
        eacc_pkg::FILTER_PERIOD_RESET[eacc_pkg::HIGHPASS_CORNER_LSB +: 3];
      highpass_active_ff       <= 1'b0;
      noload_log2_ff           <= 4'h0;
      noload_enable_ff         <= 1'b0;
      reverse_reactive_flag_ff <= 1'b0;
      reverse_active_flag_ff   <= 1'b0;
      energy_clear_ff          <= 1'b0;
      energy_load_mode_ff      <= 1'b0;
      energy_interval_mode_ff  <= 1'b0;
      accumulator_run_ff       <= 1'b0;
    end
    else
    begin
      use_user_period_ff       <= nxt_use_user_period;
      highpass_corner_ff       <= nxt_hp_corner;
      highpass_active_ff       <= nxt_hp_active;
      noload_log2_ff           <= nxt_noload_log2;
      noload_enable_ff         <= nxt_noload_en;
      reverse_reactive_flag_ff <= nxt_rev_reactive;
      reverse_active_flag_ff   <= nxt_rev_active;
      energy_clear_ff          <= nxt_energy_clear;
      energy_load_mode_ff      <= nxt_load_mode;
      energy_interval_mode_ff  <= nxt_interval_mode;
      accumulator_run_ff       <= nxt_acc_run;
    end
  end

  // ------------------------------------------------------------
  // Checksum engine and done flag
  // ------------------------------------------------------------
  // A start landing while a run still drains is dropped on both sides, so the
  // engine can never rescan while busy already reads low
  logic        crc_launch;
  assign crc_launch = crc_start_ff && !checksum_busy_ff;

  eacc_crc_engine u_crc
  (
    .mclk       (mclk),
    .reset      (reset),
    .start      (crc_launch),
    .cover_en   (coverage_ff[eacc_pkg::COVER_LSB +: eacc_pkg::COVER_COUNT]),
    .cover_data (cover_data),
    .done_pulse (crc_done_pulse),
    .crc_value  (crc_result)
  );

  logic        nxt_crc_done;
  logic        nxt_crc_busy;
  logic [15:0] nxt_crc_value;

  // Done flag is sticky until a new run; a done in the start cycle still wins
  always_comb
  begin
    nxt_crc_done  = checksum_done_ff;
    nxt_crc_busy  = checksum_busy_ff;
    nxt_crc_value = checksum_value_ff;
    // Busy gates new starts so one run is never restarted half way
    if (crc_launch)
    begin
      nxt_crc_done = 1'b0;
      nxt_crc_busy = 1'b1;
    end
    if (crc_done_pulse)
    begin
      nxt_crc_done  = 1'b1;
      nxt_crc_busy  = 1'b0;
      nxt_crc_value = crc_result;
    end
  end

  // Checksum status register stage
  always_ff @(posedge mclk)
  begin
    if (reset)
    begin
      checksum_done_ff  <= 1'b0;
      checksum_busy_ff  <= 1'b0;
      checksum_value_ff <= 16'h0000;
    end
    else
    begin
      checksum_done_ff  <= nxt_crc_done;
      checksum_busy_ff  <= nxt_crc_busy;
      checksum_value_ff <= nxt_crc_value;
    end
  end

endmodule
`default_nettype wire

/* hdl/eacc_crc_engine.sv */
// Module: configuration checksum engine walking the covered registers
`default_nettype none
module eacc_crc_engine
(
  // Clock and reset
  input  wire logic                         mclk,
  input  wire logic                         reset,
  // Control
  input  wire logic                         start,
  input  wire logic [eacc_pkg::COVER_COUNT-1:0] cover_en,
  input  wire logic [16*eacc_pkg::COVER_COUNT-1:0] cover_data,
  // Result
  output var  logic                         done_pulse,
  output var  logic [15:0]                  crc_value
);

  // ------------------------------------------------------------
  // Checksum step function
  // ------------------------------------------------------------
  function automatic logic [15:0] crc_word(input logic [15:0] crc, input logic [15:0] word);
    logic [15:0] c;
    c = crc ^ word;
    for (int i = 0; i < 16; i++)
    begin
      c = c[15] ? ((c << 1) ^ eacc_pkg::CRC_POLY) : (c << 1);
    end
    return c;
  endfunction

  eacc_pkg::eacc_crc_state_t state_ff;
  eacc_pkg::eacc_crc_state_t nxt_state;
  logic [2:0]  idx_ff;
  logic [2:0]  nxt_idx;
  logic [15:0] crc_ff;
  logic [15:0] nxt_crc;
  logic        done_ff;
  logic        nxt_done;
  logic [15:0] result_ff;
  logic [15:0] nxt_result;

  // ------------------------------------------------------------
  // One covered register per cycle, skipped ones cost a cycle too
  // ------------------------------------------------------------
  always_comb
  begin
    nxt_state  = state_ff;
    nxt_idx    = idx_ff;
    nxt_crc    = crc_ff;
    nxt_done   = 1'b0;
    nxt_result = result_ff;
    case (state_ff)
      eacc_pkg::EACC_IDLE:
      begin
        if (start)
        begin
          nxt_state = eacc_pkg::EACC_SCAN;
          nxt_idx   = 3'h0;
          nxt_crc   = eacc_pkg::CRC_SEED;
        end
      end
      eacc_pkg::EACC_SCAN:
      begin
        if (cover_en[idx_ff])
        begin
          nxt_crc = crc_word(crc_ff, cover_data[16*idx_ff +: 16]);
        end
        if (idx_ff == 3'(eacc_pkg::COVER_COUNT - 1))
        begin
          nxt_state = eacc_pkg::EACC_DONE;
        end
        else
        begin
          nxt_idx = idx_ff + 3'h1;
        end
      end
      eacc_pkg::EACC_DONE:
      begin
        nxt_result = crc_ff;
        nxt_done   = 1'b1;
        nxt_state  = eacc_pkg::EACC_IDLE;
      end
      default:
      begin
        nxt_state = eacc_pkg::EACC_IDLE;
      end
    endcase
  end

  // Register stage
  always_ff @(posedge mclk)
  begin
    if (reset)
    begin
      state_ff  <= eacc_pkg::EACC_IDLE;
      idx_ff    <= 3'h0;
      crc_ff    <= eacc_pkg::CRC_SEED;
      done_ff   <= 1'b0;
      result_ff <= 16'h0000;
    end
    else
    begin
      state_ff  <= nxt_state;
      idx_ff    <= nxt_idx;
      crc_ff    <= nxt_crc;
      done_ff   <= nxt_done;
      result_ff <= nxt_result;
    end
  end

  assign done_pulse = done_ff;
  assign crc_value  = result_ff;

endmodule
`default_nettype wire

/* inc/eacc_pkg.sv */
// Package: register map, field layout and constants for the energy/checksum config slice
`default_nettype none
package eacc_pkg;
  // ------------------------------------------------------------
  // Register offsets (internal register port)
  // ------------------------------------------------------------
  localparam logic [11:0] FILTER_PERIOD_CONFIG_ADDR = 12'h4AF;
  localparam logic [11:0] ENERGY_POWER_CONFIG_ADDR  = 12'h4B0;
  localparam logic [11:0] CHECKSUM_TRIGGER_ADDR     = 12'h4B4;
  localparam logic [11:0] CHECKSUM_COVERAGE_ADDR    = 12'h4B5;

  // ------------------------------------------------------------
  // Field positions and writable masks
  // ------------------------------------------------------------
  localparam int USER_PERIOD_SELECT_BIT   = 12;
  localparam int HIGHPASS_CORNER_LSB      = 9;
  localparam int NOLOAD_WINDOW_LSB        = 13;
  localparam int SIGN_SEL_REACTIVE_BIT    = 7;
  localparam int SIGN_SEL_ACTIVE_BIT      = 6;
  localparam int CLEAR_ON_READ_BIT        = 5;
  localparam int ENERGY_LOAD_MODE_BIT     = 4;
  localparam int ENERGY_INTERVAL_MODE_BIT = 1;
  localparam int ACCUMULATOR_ENABLE_BIT   = 0;
  localparam int CHECKSUM_FORCE_BIT       = 0;
  localparam int COVER_LSB                = 10;
  localparam int COVER_COUNT              = 6;

  localparam logic [15:0] FILTER_PERIOD_MASK = 16'h1E00;
  localparam logic [15:0] ENERGY_POWER_MASK  = 16'hE0F3;
  localparam logic [15:0] COVERAGE_MASK      = 16'hFC00;

  // ------------------------------------------------------------
  // Reset values
  // ------------------------------------------------------------
  localparam logic [15:0] FILTER_PERIOD_RESET = 16'h0C00;
  localparam logic [15:0] ENERGY_POWER_RESET  = 16'h0000;
  localparam logic [15:0] COVERAGE_RESET      = 16'h0000;

  // ------------------------------------------------------------
  // Checksum engine and no-load window constants
  // ------------------------------------------------------------
  localparam logic [15:0] CRC_SEED = 16'hFFFF;
  localparam logic [15:0] CRC_POLY = 16'h1021;
  localparam logic [2:0]  NOLOAD_DISABLE_CODE = 3'h7;
  localparam logic [3:0]  NOLOAD_BASE_LOG2    = 4'h6;

  typedef enum logic [1:0]
  {
    EACC_IDLE = 2'b00,
    EACC_SCAN = 2'b01,
    EACC_DONE = 2'b11
  } eacc_crc_state_t;
endpackage
`default_nettype wire

/* testbench/eacc_config_monitor.sv */
// Checker: port-level assertions for the energy and checksum configuration slice
`default_nettype none
module eacc_config_monitor
(
  // Clock and reset
  input wire logic        mclk,
  input wire logic        reset,
  // Register port
  input wire logic        reg_wr,
  input wire logic        reg_rd,
  input wire logic [11:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic [15:0] reg_rdata_ff,
  // Device context
  input wire logic        run_bit,
  input wire logic        highpass_disable,
  input wire logic        energy_read_strobe,
  input wire logic        total_reactive_sign,
  input wire logic        fund_reactive_sign,
  input wire logic        total_active_sign,
  input wire logic        fund_active_sign,
  // Settings and status
  input wire logic        use_user_period_ff,
  input wire logic [2:0]  highpass_corner_ff,
  input wire logic        highpass_active_ff,
  input wire logic [3:0]  noload_log2_ff,
  input wire logic        noload_enable_ff,
  input wire logic        reverse_reactive_flag_ff,
  input wire logic        reverse_active_flag_ff,
  input wire logic        energy_clear_ff,
  input wire logic        energy_load_mode_ff,
  input wire logic        energy_interval_mode_ff,
  input wire logic        accumulator_run_ff,
  input wire logic        checksum_done_ff,
  input wire logic        checksum_busy_ff
);
  // ------------------------------------------------------------
  // Shadow registers
  // ------------------------------------------------------------
  logic        prev_wr_ff, nxt_prev_wr, prev_rst_ff, nxt_prev_rst;
  logic [15:0] fp_ff, nxt_fp, ep_ff, nxt_ep, cv_ff, nxt_cv;
  // Settings are only judged two quiet cycles after a write or reset
  wire logic   calm = !reset && !prev_rst_ff && !reg_wr && !prev_wr_ff;
  wire logic   go = reg_wr && reg_addr == 12'h4B4 && reg_wdata[0];
  wire logic [15:0] rd_exp = reg_addr == 12'h4AF ? fp_ff : reg_addr == 12'h4B0 ? ep_ff :
                             reg_addr == 12'h4B5 ? cv_ff : 16'h0000;
  // Masked copy of every host write to 4AF, 4B0 and 4B5
  always_comb
  begin
    nxt_prev_wr = reg_wr;
    nxt_prev_rst = reset;
    nxt_fp = (reg_wr && reg_addr == 12'h4AF) ? reg_wdata & 16'h1E00 : fp_ff;
    nxt_ep = (reg_wr && reg_addr == 12'h4B0) ? reg_wdata & 16'hE0F3 : ep_ff;
    nxt_cv = (reg_wr && reg_addr == 12'h4B5) ? reg_wdata & 16'hFC00 : cv_ff;
    if (reset)
    begin
      nxt_fp = 16'h0C00;
      nxt_ep = 16'h0000;
      nxt_cv = 16'h0000;
    end
  end
  always_ff @(posedge mclk)
  begin
    {prev_wr_ff, prev_rst_ff} <= {nxt_prev_wr, nxt_prev_rst};
    {fp_ff, ep_ff, cv_ff} <= {nxt_fp, nxt_ep, nxt_cv};
  end
  // ------------------------------------------------------------
  // Properties
  // ------------------------------------------------------------
  default clocking @(posedge mclk); endclocking
  default disable iff (reset);
  a_read_back: assert property (reg_rd |=> reg_rdata_ff == $past(rd_exp))
    else $error("read data differs from register contents");
  a_idle_read_zero: assert property (!reg_rd |=> reg_rdata_ff == 16'h0000)
    else $error("read data not zero without a read");
  a_period_corner: assert property (calm && $stable(highpass_disable) |=>
    highpass_corner_ff == fp_ff[11:9] && use_user_period_ff == fp_ff[12] &&
    highpass_active_ff == !$past(highpass_disable))
    else $error("period or corner setting wrong");
  a_noload_window: assert property (calm |=>
    noload_enable_ff == (ep_ff[15:13] != 3'h7) &&
    (ep_ff[15:13] == 3'h7 || noload_log2_ff == 4'h6 + ep_ff[15:13]))
    else $error("no-load window wrong");
  a_reactive_src: assert property (
    calm && $stable({total_reactive_sign, fund_reactive_sign}) |=>
    reverse_reactive_flag_ff == $past(ep_ff[7] ? fund_reactive_sign : total_reactive_sign))
    else $error("reactive flag source wrong");
  a_active_src: assert property (
    calm && $stable({total_active_sign, fund_active_sign}) |=>
    reverse_active_flag_ff == $past(ep_ff[6] ? fund_active_sign : total_active_sign))
    else $error("active flag source wrong");
  a_clear_pulse: assert property (calm && energy_read_strobe |=>
    energy_clear_ff == ep_ff[5])
    else $error("clear pulse wrong");
  a_clear_quiet: assert property (!energy_read_strobe |=> !energy_clear_ff)
    else $error("clear pulse without read");
  a_mode_bits: assert property (calm |=> energy_load_mode_ff == ep_ff[4] &&
    energy_interval_mode_ff == ep_ff[1])
    else $error("load or interval mode wrong");
  a_run_gate: assert property (calm && $stable(run_bit) |=>
    accumulator_run_ff == (ep_ff[0] && $past(run_bit)))
    else $error("accumulator run gating wrong");
  a_crc_latency: assert property (go && !checksum_busy_ff && !prev_wr_ff |->
    ##2 checksum_busy_ff ##8 checksum_done_ff && !checksum_busy_ff)
    else $error("checksum did not finish on time");
  a_done_sticky: assert property (calm && checksum_done_ff |=> checksum_done_ff)
    else $error("checksum done dropped without a start");
  c_crc_done: cover property (go ##10 checksum_done_ff);
  c_clear: cover property (energy_clear_ff);
  c_read_ep: cover property (reg_rd && reg_addr == 12'h4B0);
endmodule
bind eacc_config eacc_config_monitor u_mon (.mclk, .reset, .reg_wr, .reg_rd, .reg_addr,
  .reg_wdata, .reg_rdata_ff, .run_bit, .highpass_disable, .energy_read_strobe,
  .total_reactive_sign, .fund_reactive_sign, .total_active_sign, .fund_active_sign,
  .use_user_period_ff, .highpass_corner_ff, .highpass_active_ff, .noload_log2_ff,
  .noload_enable_ff, .reverse_reactive_flag_ff, .reverse_active_flag_ff, .energy_clear_ff,
  .energy_load_mode_ff, .energy_interval_mode_ff, .accumulator_run_ff, .checksum_done_ff,
  .checksum_busy_ff);
`default_nettype wire

/* testbench/tb.sv */
// Testbench: random and corner register traffic against the configuration slice
`default_nettype none
module tb;
  timeunit 1ns;
  timeprecision 100ps;
  // ------------------------------------------------------------
  // Signals and bench state
  // ------------------------------------------------------------
  logic        mclk = 1'b0, reset = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0;
  logic        run_bit = 1'b0, hpd = 1'b0, strobe = 1'b0;
  logic [3:0]  sg = 4'h0;
  logic [11:0] reg_addr = 12'h000;
  logic [15:0] reg_wdata = 16'h0000, rdata, crcv, q, d;
  logic [95:0] cover_data = 96'h0;
  logic [2:0]  crn, k = 3'h0;
  logic [3:0]  nl2;
  logic        up, hpa, nle, rrf, raf, clr, ldm, ivm, run, done, busy;
  logic [15:0] fp = 16'h0C00, ep = 16'h0000, cv = 16'h0000;
  logic [11:0] adr [5] = '{12'h4AF, 12'h4B0, 12'h4B5, 12'h4B3, 12'h4B0};
  int          mismatches = 0, checks_done = 0, n;
  int          seed = 32'hE327C9F4;
  eacc_config u_dut (.mclk(mclk), .reset(reset), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata_ff(rdata), .run_bit(run_bit),
    .highpass_disable(hpd), .energy_read_strobe(strobe), .total_reactive_sign(sg[3]),
    .fund_reactive_sign(sg[2]), .total_active_sign(sg[1]), .fund_active_sign(sg[0]),
    .cover_data(cover_data), .use_user_period_ff(up), .highpass_corner_ff(crn),
    .highpass_active_ff(hpa), .noload_log2_ff(nl2), .noload_enable_ff(nle),
    .reverse_reactive_flag_ff(rrf), .reverse_active_flag_ff(raf), .energy_clear_ff(clr),
    .energy_load_mode_ff(ldm), .energy_interval_mode_ff(ivm), .accumulator_run_ff(run),
    .checksum_done_ff(done), .checksum_busy_ff(busy), .checksum_value_ff(crcv));
  // 200 MHz clock
  always #2.5 mclk = ~mclk;
  // ------------------------------------------------------------
  // Tasks and reference functions
  // ------------------------------------------------------------
  task automatic step(input int c);
    repeat (c) @(posedge mclk);
    #1;
  endtask
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checks_done++;
    if (got !== exp)
    begin
      mismatches++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [11:0] a, input logic [15:0] v);
    reg_wr = 1'b1;
    reg_addr = a;
    reg_wdata = v;
    step(1);
    reg_wr = 1'b0;
    // Let an edge pass so a following strobe never rises in the same step
    step(1);
  endtask
  // Read data is registered, so it is taken one edge after the request
  task automatic rd(input logic [11:0] a);
    reg_rd = 1'b1;
    reg_addr = a;
    step(1);
    q = rdata;
    reg_rd = 1'b0;
    step(1);
  endtask
  function automatic logic [15:0] exp_rd(input logic [11:0] a);
    exp_rd = a == 12'h4AF ? fp : a == 12'h4B0 ? ep : a == 12'h4B5 ? cv : 16'h0000;
  endfunction
  function automatic logic [15:0] exp_set();
    exp_set = {fp[12], fp[11:9], ~hpd, ep[15:13] != 3'h7, ep[7] ? sg[2] : sg[3],
               ep[6] ? sg[0] : sg[1], ep[4], ep[1], ep[0] & run_bit, 5'h00};
  endfunction
  // Bitwise CRC so the reference shares nothing with the engine
  function automatic logic [15:0] crc_of(input logic [15:0] c, input logic [95:0] w);
    logic [15:0] r;
    r = 16'hFFFF;
    for (int i = 0; i < 6; i++)
      if (c[10+i])
        for (int b = 15; b >= 0; b--)
          r = {r[14:0], 1'b0} ^ ((r[15] ^ w[16*i+b]) ? 16'h1021 : 16'h0000);
    crc_of = r;
  endfunction
  task automatic end_of_test();
    $display("checks_done=%0d mismatches=%0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  // Watchdog far beyond the few hundred cycles the sequence needs
  initial
  begin
    #100000;
    mismatches++;
    end_of_test();
  end
  // ------------------------------------------------------------
  // Main sequence
  // ------------------------------------------------------------
  initial
  begin
    step(4);
    reset = 1'b0;
    step(1);
    chk({13'h0, crn}, 16'h0006);
    for (int i = 0; i < 5; i++)
    begin
      rd(adr[i]);
      chk(q, exp_rd(adr[i]));
    end
    // Random writes; no-load codes walk all eight values
    for (int i = 0; i < 24; i++)
    begin
      d = 16'($random(seed));
      if (adr[i%5] == 12'h4B0)
      begin
        d[15:13] = k;
        k++;
      end
      sg = 4'($random(seed));
      run_bit = 1'($random(seed));
      hpd = 1'($random(seed));
      wr(adr[i%5], d);
      case (adr[i%5])
        12'h4AF: fp = d & 16'h1E00;
        12'h4B0: ep = d & 16'hE0F3;
        12'h4B5: cv = d & 16'hFC00;
        default: ;
      endcase
      rd(adr[i%5]);
      chk(q, exp_rd(adr[i%5]));
      step(2);
      chk({up, crn, hpa, nle, rrf, raf, ldm, ivm, run, 5'h00}, exp_set());
      if (ep[15:13] != 3'h7)
        chk({12'h000, nl2}, 16'h0006 + ep[15:13]);
    end
    // Clear-on-read pulse with the enable set, then clear
    for (int j = 1; j >= 0; j--)
    begin
      wr(12'h4B0, j ? 16'h0020 : 16'h0000);
      strobe = 1'b1;
      step(1);
      strobe = 1'b0;
      chk({15'h0, clr}, 16'(j));
      step(1);
      chk({15'h0, clr}, 16'h0000);
    end
    // Checksum over full, empty and random coverage
    for (int j = 0; j < 3; j++)
    begin
      cv = j == 0 ? 16'hFC00 : j == 1 ? 16'h0000 : 16'($random(seed)) & 16'hFC00;
      cover_data = {$random(seed), $random(seed), $random(seed)};
      wr(12'h4B5, cv | 16'h03FF);
      step(1);
      wr(12'h4B4, 16'hFFFF);
      step(2);
      n = 0;
      while (done !== 1'b1 && n < 40)
      begin
        step(1);
        n++;
      end
      chk({15'h0, done}, 16'h0001);
      chk(crcv, crc_of(cv, cover_data));
      rd(12'h4B4);
      chk(q, 16'h0000);
    end
    end_of_test();
  end
endmodule
`default_nettype wire
